// [seb_map.vh]
// Boot loader constants: device address, byte layout, serial clock timing
`ifndef SEB_MAP_VH
`define SEB_MAP_VH

`define SEB_DEV_PREFIX   4'ha
`define SEB_CTRL_WR      8'ha0
`define SEB_CTRL_RD      8'ha1
`define SEB_WORD_ADDR0   8'h00

`define SEB_FIRST_DIV    1000
// Quarter of the first-byte serial clock, one fourth of SEB_FIRST_DIV
`define SEB_QTR_FIRST    9'h0fa
`define SEB_QTR_STD_100  9'h0fa
`define SEB_QTR_STD_75   9'h0bc
`define SEB_QTR_STD_50   9'h07d
`define SEB_QTR_STD_33   9'h053
`define SEB_QTR_FST_100  9'h03f
`define SEB_QTR_FST_75   9'h02f
`define SEB_QTR_FST_50   9'h020
`define SEB_QTR_FST_33   9'h015

`define SEB_B0_SPEED_LO  4
`define SEB_B0_FAST      6
`define SEB_MODE_BIT     7

`define SEB_IDX_MODE     11'h009
`define SEB_IDX_MBASE_HI 11'h00a
`define SEB_IDX_MBASE_LO 11'h00b
`define SEB_IDX_RBASE_HI 11'h00c
`define SEB_IDX_RBASE_LO 11'h00d
`define SEB_IDX_LEN_HI   11'h00e
`define SEB_IDX_LEN_LO   11'h00f
`define SEB_PROG_START   11'h010
`define SEB_PROG_MAX     11'h7f0

`endif

// [seb_pair_buf.v]
// Two-entry buffer with valid and ready on both sides, registered outputs
`timescale 1ns/1ps
module seb_pair_buf #(
    parameter WIDTH = 19
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             empty
);

reg [WIDTH-1:0] head_ff;
reg [WIDTH-1:0] tail_ff;
reg [1:0]       cnt_ff;

wire push = in_valid && in_ready;
wire pop  = out_valid && out_ready;

assign in_ready  = (cnt_ff != 2'h2);
assign out_valid = (cnt_ff != 2'h0);
assign out_data  = head_ff;
assign empty     = (cnt_ff == 2'h0);

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        head_ff <= {WIDTH{1'b0}};
        tail_ff <= {WIDTH{1'b0}};
        cnt_ff  <= 2'h0;
    end
    else
    begin
        if (pop)
        begin
            head_ff <= (cnt_ff == 2'h2) ? tail_ff : in_data;
        end
        else if (push && cnt_ff == 2'h0)
        begin
            head_ff <= in_data;
        end
        if (push && (cnt_ff == 2'h2 || (cnt_ff == 2'h1 && !pop)))
        begin
            tail_ff <= in_data;
        end
        // Push into a full buffer cannot happen: in_ready is low
        if (push && !pop)
        begin
            cnt_ff <= cnt_ff + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_ff <= cnt_ff - 2'h1;
        end
    end
end

endmodule // seb_pair_buf

// [seb_boot_loader.v]
// Serial EEPROM boot loader: reads boot image over two-wire bus, releases core
//
// Behaviour
// - Own logic reads one serial EEPROM, sets memory and clock config alone.
// - Tenth byte top bit picks host-assisted or autonomous boot.
// - One standard EEPROM from 128 bytes up to 2KB.
// - Host-assisted mode loads only timing and memory interface setup.
// - Host-assisted mode reads no more than the first ten bytes.
// - Autonomous mode sets aperture bases then copies bootstrap into memory.
// - Autonomous bootstrap may fill nearly the whole 2KB device.
// - Core and highway held in reset; released per boot mode.
// - First byte at boot clock over 1000, then fastest allowed rate.
`timescale 1ns/1ps
`include "seb_map.vh"
module seb_boot_loader (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Two-wire bus, open drain
    input  wire        scl_in,
    output wire        scl_out,
    output wire        scl_oe,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    // Loaded configuration
    output wire [79:0] boot_cfg_bytes,
    output wire        host_assisted,
    output wire [15:0] mem_aperture_base,
    output wire [15:0] reg_aperture_base,
    // Bootstrap program write stream
    output wire        prog_wr_valid,
    input  wire        prog_wr_ready,
    output wire [10:0] prog_wr_addr,
    output wire [7:0]  prog_wr_data,
    // Boot status and releases
    output wire        highway_release,
    output wire        core_release,
    output wire        boot_busy,
    output wire        boot_error
);

localparam [3:0] ST_START  = 4'h0;
localparam [3:0] ST_CTRLW  = 4'h1;
localparam [3:0] ST_ADDR   = 4'h2;
localparam [3:0] ST_RSTART = 4'h3;
localparam [3:0] ST_CTRLR  = 4'h4;
localparam [3:0] ST_READ   = 4'h5;
localparam [3:0] ST_STOP   = 4'h6;
localparam [3:0] ST_DONE   = 4'h7;
localparam [3:0] ST_FAIL   = 4'h8;

localparam [8:0] QTR_FIRST = `SEB_QTR_FIRST;

reg  [3:0]  st_ff;
reg  [1:0]  ph_ff;
reg  [8:0]  q_ff;
reg  [3:0]  bit_ff;
reg  [8:0]  sh_ff;
reg  [10:0] idx_ff;
reg  [10:0] len_ff;
reg  [79:0] cfg_ff;
reg  [15:0] mbase_ff;
reg  [15:0] rbase_ff;
reg         host_ff;
reg         rate_ok_ff;
reg         nack_ff;
reg         scl_rel_ff;
reg         sda_rel_ff;
reg         scl_m_ff;
reg         scl_s_ff;
reg         sda_m_ff;
reg         sda_s_ff;
reg         scl_rel_m_ff;
reg         scl_rel_s_ff;
reg         hw_rel_ff;
reg         core_rel_ff;
reg  [8:0]  qtr_sel;
reg         nxt_scl_rel;
reg         nxt_sda_rel;

wire [1:0]  np = ph_ff + 2'h1;
wire        is_bit   = (st_ff == ST_CTRLW) || (st_ff == ST_ADDR) ||
                       (st_ff == ST_CTRLR) || (st_ff == ST_READ);
wire        is_write = is_bit && (st_ff != ST_READ);
wire [7:0]  rx_byte  = {sh_ff[6:0], sda_s_ff};
wire        prog_byte = (idx_ff >= `SEB_PROG_START);
wire [10:0] last_prog = len_ff + `SEB_IDX_LEN_LO;
wire        is_last  = (idx_ff == `SEB_IDX_MODE && host_ff) ||
                       (idx_ff == `SEB_IDX_LEN_LO && len_ff == 11'h000) ||
                       (prog_byte && idx_ff == last_prog);
// Release is compared with a copy delayed like the synchroniser, so its lag is not stretching
wire        stretch  = scl_rel_ff && scl_rel_s_ff && !scl_s_ff;
wire        push_pt  = (st_ff == ST_READ) && (ph_ff == 2'h3) && (bit_ff == 4'h7) &&
                       prog_byte && (q_ff == 9'h000) && !stretch;
wire        buf_ready;
wire        buf_empty;
// Master holds SCL high while the buffer is full, so no byte is lost
wire        stall    = push_pt && !buf_ready;
wire        run      = (st_ff != ST_DONE) && (st_ff != ST_FAIL);
wire        tick     = run && (q_ff == 9'h000) && !stall && !stretch;
wire        bit_end  = tick && (ph_ff == 2'h3);

always @*
begin
    qtr_sel = QTR_FIRST;
    if (rate_ok_ff)
    begin
        case ({cfg_ff[`SEB_B0_FAST], cfg_ff[`SEB_B0_SPEED_LO+1:`SEB_B0_SPEED_LO]})
            3'h0:    qtr_sel = `SEB_QTR_STD_100;
            3'h1:    qtr_sel = `SEB_QTR_STD_75;
            3'h2:    qtr_sel = `SEB_QTR_STD_50;
            3'h3:    qtr_sel = `SEB_QTR_STD_33;
            3'h4:    qtr_sel = `SEB_QTR_FST_100;
            3'h5:    qtr_sel = `SEB_QTR_FST_75;
            3'h6:    qtr_sel = `SEB_QTR_FST_50;
            default: qtr_sel = `SEB_QTR_FST_33;
        endcase
    end
end

// Pin levels for the quarter about to begin
always @*
begin
    nxt_scl_rel = scl_rel_ff;
    nxt_sda_rel = sda_rel_ff;
    case (st_ff)
        ST_START, ST_RSTART:
        begin
            nxt_scl_rel = (np == 2'h1) || (np == 2'h2);
            nxt_sda_rel = (np == 2'h0) || (np == 2'h1);
        end
        ST_STOP:
        begin
            // SCL stays released once the stop condition is on the bus
            nxt_scl_rel = np[1] || (np == 2'h0);
            nxt_sda_rel = (np == 2'h0) ? sda_rel_ff : (np == 2'h3);
        end
        ST_CTRLW, ST_ADDR, ST_CTRLR, ST_READ:
        begin
            nxt_scl_rel = np[1];
            // Data changes one quarter after SCL falls for hold margin
            if (np == 2'h1)
            begin
                if (is_write)
                    nxt_sda_rel = sh_ff[8];
                else if (bit_ff == 4'h8)
                    nxt_sda_rel = is_last;
                else
                    nxt_sda_rel = 1'b1;
            end
        end
        default:
        begin
            nxt_scl_rel = 1'b1;
            nxt_sda_rel = 1'b1;
        end
    endcase
end

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        scl_m_ff <= 1'b1;
        scl_s_ff <= 1'b1;
        sda_m_ff <= 1'b1;
        sda_s_ff <= 1'b1;
        scl_rel_m_ff <= 1'b1;
        scl_rel_s_ff <= 1'b1;
    end
    else
    begin
        scl_m_ff <= scl_in;
        scl_s_ff <= scl_m_ff;
        sda_m_ff <= sda_in;
        sda_s_ff <= sda_m_ff;
        scl_rel_m_ff <= scl_rel_ff;
        scl_rel_s_ff <= scl_rel_m_ff;
    end
end

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        st_ff       <= ST_START;
        ph_ff       <= 2'h0;
        q_ff        <= 9'h000;
        bit_ff      <= 4'h0;
        sh_ff       <= 9'h000;
        idx_ff      <= 11'h000;
        len_ff      <= 11'h000;
        cfg_ff      <= 80'h0;
        mbase_ff    <= 16'h0000;
        rbase_ff    <= 16'h0000;
        host_ff     <= 1'b0;
        rate_ok_ff  <= 1'b0;
        nack_ff     <= 1'b0;
        scl_rel_ff  <= 1'b1;
        sda_rel_ff  <= 1'b1;
        hw_rel_ff   <= 1'b0;
        core_rel_ff <= 1'b0;
    end
    else
    begin
        if (run && q_ff != 9'h000 && !stretch)
        begin
            q_ff <= q_ff - 9'h001;
        end
        if (tick)
        begin
            q_ff       <= qtr_sel - 9'h001;
            ph_ff      <= np;
            scl_rel_ff <= nxt_scl_rel;
            sda_rel_ff <= nxt_sda_rel;
        end
        if (bit_end)
        begin
            case (st_ff)
                ST_START:
                begin
                    st_ff  <= ST_CTRLW;
                    bit_ff <= 4'h0;
                    sh_ff  <= {`SEB_CTRL_WR, 1'b1};
                end
                ST_RSTART:
                begin
                    st_ff  <= ST_CTRLR;
                    bit_ff <= 4'h0;
                    sh_ff  <= {`SEB_CTRL_RD, 1'b1};
                end
                ST_CTRLW, ST_ADDR, ST_CTRLR:
                begin
                    if (bit_ff != 4'h8)
                    begin
                        bit_ff <= bit_ff + 4'h1;
                        sh_ff  <= {sh_ff[7:0], 1'b1};
                    end
                    else if (sda_s_ff)
                    begin
                        nack_ff <= 1'b1;
                        st_ff   <= ST_STOP;
                    end
                    else
                    begin
                        bit_ff <= 4'h0;
                        // Sequential read from word 0 spans any size up to 2KB
                        if (st_ff == ST_CTRLW)
                        begin
                            st_ff <= ST_ADDR;
                            sh_ff <= {`SEB_WORD_ADDR0, 1'b1};
                        end
                        else if (st_ff == ST_ADDR)
                            st_ff <= ST_RSTART;
                        else
                            st_ff <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    if (bit_ff != 4'h8)
                    begin
                        bit_ff <= bit_ff + 4'h1;
                        sh_ff  <= {sh_ff[7:0], sda_s_ff};
                    end
                    else if (is_last)
                        st_ff <= ST_STOP;
                    else
                    begin
                        bit_ff <= 4'h0;
                        idx_ff <= idx_ff + 11'h001;
                    end
                    if (bit_ff == 4'h7)
                    begin
                        if (idx_ff < `SEB_IDX_MBASE_HI)
                            cfg_ff[idx_ff*8 +: 8] <= rx_byte;
                        if (idx_ff == 11'h000)
                            rate_ok_ff <= 1'b1;
                        if (idx_ff == `SEB_IDX_MODE)
                            host_ff <= !rx_byte[`SEB_MODE_BIT];
                        if (idx_ff == `SEB_IDX_MBASE_HI)
                            mbase_ff[15:8] <= rx_byte;
                        if (idx_ff == `SEB_IDX_MBASE_LO)
                            mbase_ff[7:0] <= rx_byte;
                        if (idx_ff == `SEB_IDX_RBASE_HI)
                            rbase_ff[15:8] <= rx_byte;
                        if (idx_ff == `SEB_IDX_RBASE_LO)
                            rbase_ff[7:0] <= rx_byte;
                        if (idx_ff == `SEB_IDX_LEN_HI)
                            len_ff[10:8] <= rx_byte[2:0];
                        // Length beyond the device is clamped
                        if (idx_ff == `SEB_IDX_LEN_LO)
                            len_ff <= ({len_ff[10:8], rx_byte} > `SEB_PROG_MAX) ?
                                      `SEB_PROG_MAX : {len_ff[10:8], rx_byte};
                    end
                end
                ST_STOP:
                    st_ff <= nack_ff ? ST_FAIL : ST_DONE;
                default:
                    st_ff <= st_ff;
            endcase
        end
        if (st_ff == ST_DONE)
        begin
            hw_rel_ff <= 1'b1;
            if (!host_ff && buf_empty)
                core_rel_ff <= 1'b1;
        end
    end
end

seb_pair_buf #(
    .WIDTH (19)
) u_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push_pt),
    .in_ready  (buf_ready),
    .in_data   ({idx_ff - `SEB_PROG_START, rx_byte}),
    .out_valid (prog_wr_valid),
    .out_ready (prog_wr_ready),
    .out_data  ({prog_wr_addr, prog_wr_data}),
    .empty     (buf_empty)
);

assign scl_out           = 1'b0;
assign sda_out           = 1'b0;
assign scl_oe            = !scl_rel_ff;
assign sda_oe            = !sda_rel_ff;
assign boot_cfg_bytes    = cfg_ff;
assign host_assisted     = host_ff;
assign mem_aperture_base = mbase_ff;
assign reg_aperture_base = rbase_ff;
assign highway_release   = hw_rel_ff;
assign core_release      = core_rel_ff;
assign boot_busy         = run;
assign boot_error        = (st_ff == ST_FAIL);

endmodule // seb_boot_loader

// [seb_boot_props.sv]
// Concurrent checks on the boot loader ports
`timescale 1ns/1ps
module seb_boot_props (
    // Clock and reset
    input wire        clk,
    input wire        reset_n,
    // Bus pins
    input wire        scl_out,
    input wire        scl_oe,
    input wire        sda_out,
    input wire        sda_oe,
    // Stream and status
    input wire        host_assisted,
    input wire        prog_wr_valid,
    input wire        prog_wr_ready,
    input wire [10:0] prog_wr_addr,
    input wire [7:0]  prog_wr_data,
    input wire        highway_release,
    input wire        core_release,
    input wire        boot_busy,
    input wire        boot_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_pins_pull_low: assert property (!scl_out && !sda_out)
        else $error("bus pin value not low");
    a_core_needs_hwy: assert property (core_release |-> highway_release)
        else $error("core released before highway");
    a_core_only_auto: assert property (core_release |-> !host_assisted)
        else $error("core released in host mode");
    a_hwy_sticky: assert property (highway_release |=> highway_release)
        else $error("highway release dropped");
    a_error_no_rel: assert property (boot_error |-> !highway_release)
        else $error("release after refused byte");
    a_done_bus_free: assert property (!boot_busy |-> !scl_oe && !sda_oe)
        else $error("bus held after loading");
    a_stall_holds: assert property (prog_wr_valid && !prog_wr_ready |=>
        prog_wr_valid && $stable(prog_wr_addr) && $stable(prog_wr_data))
        else $error("program word changed while stalled");
    a_core_drained: assert property ($rose(core_release) |-> !prog_wr_valid)
        else $error("core released with words pending");
    a_prog_auto: assert property (prog_wr_valid |-> !host_assisted)
        else $error("program stream in host mode");
    a_hwy_after_load: assert property ($rose(highway_release) |-> !boot_busy)
        else $error("highway released while loading");
    a_busy_holds_hwy: assert property (boot_busy |-> !highway_release && !core_release)
        else $error("release while loading");
    c_host: cover property (highway_release && host_assisted);
    c_core: cover property ($rose(core_release));
    c_stall: cover property (prog_wr_valid && !prog_wr_ready);
    c_error: cover property ($rose(boot_error));
endmodule // seb_boot_props
bind seb_boot_loader seb_boot_props u_props (
    .clk(clk), .reset_n(reset_n), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .host_assisted(host_assisted),
    .prog_wr_valid(prog_wr_valid), .prog_wr_ready(prog_wr_ready),
    .prog_wr_addr(prog_wr_addr), .prog_wr_data(prog_wr_data),
    .highway_release(highway_release), .core_release(core_release),
    .boot_busy(boot_busy), .boot_error(boot_error)
);

// [seb_eeprom_model.sv]
// Behavioural serial boot EEPROM on an open-drain two-wire bus
`timescale 1ns/1ps
module seb_eeprom_model (
    // Bus wires
    input  wire scl,
    input  wire sda,
    output reg  sda_oe,
    // Test control
    input  wire present
);
    reg [7:0]  mem [0:2047];
    reg [7:0]  sh_ff = 8'h00;
    reg [3:0]  bit_ff = 4'h0;
    reg [1:0]  phase_ff = 2'h3; // 0 control, 1 word address, 2 read, 3 idle
    reg [10:0] ptr_ff = 11'h000;
    initial sda_oe = 1'b0;
    always @(negedge sda)
        if (scl)
        begin
            phase_ff = 2'h0;
            bit_ff = 4'h0;
        end
    always @(posedge sda)
        if (scl)
            phase_ff = 2'h3;
    // Only the master ever drives the clock here
    always @(posedge scl)
        if (phase_ff != 2'h3)
        begin
            if (bit_ff < 4'h8)
            begin
                sh_ff = {sh_ff[6:0], sda};
                bit_ff = bit_ff + 4'h1;
            end
            else
            begin
                bit_ff = 4'h0;
                if (phase_ff == 2'h2)
                begin
                    ptr_ff = ptr_ff + 11'h001;
                    if (sda)
                        phase_ff = 2'h3;
                end
                else if (!sda_oe)
                    phase_ff = 2'h3;
                else if (phase_ff == 2'h1)
                begin
                    ptr_ff = {3'h0, sh_ff};
                    phase_ff = 2'h3;
                end
                else
                    phase_ff = sh_ff[0] ? 2'h2 : 2'h1;
            end
        end
    // Data changes only while the clock is low
    always @(negedge scl)
        if (phase_ff == 2'h2 && bit_ff < 4'h8)
            sda_oe = ~mem[ptr_ff][3'h7 - bit_ff[2:0]];
        else if (bit_ff == 4'h8 && phase_ff != 2'h2 && phase_ff != 2'h3)
            sda_oe = present && (phase_ff == 2'h1 || sh_ff[7:1] == 7'h50);
        else
            sda_oe = 1'b0;
endmodule // seb_eeprom_model

// [testbench.sv]
// Self-checking bench for the serial EEPROM boot loader
`timescale 1ns/1ps
module testbench;
    reg         clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         rdy = 1'b0;
    reg         present = 1'b1;
    reg         mode_r = 1'b0;
    reg [7:0]   len_r = 8'h03;
    integer     n_fail = 0;
    integer     checks_done = 0;
    integer     cyc = 0;
    integer     last_rise = 0;
    integer     n_rise = 0;
    integer     first_per = 0;
    integer     mid_per = 0;
    integer     taken = 0;
    integer     i;
    reg [79:0]  exp_cfg;
    wire        scl_out, scl_oe, sda_out, sda_oe, m_oe;
    wire [79:0] cfg;
    wire        host, pvalid, hwy, core, busy, err;
    wire [15:0] mbase, rbase;
    wire [10:0] paddr;
    wire [7:0]  pdata;
    wire        scl_w = scl_oe ? scl_out : 1'b1;
    wire        sda_w = (sda_oe ? sda_out : 1'b1) & ~m_oe;
    seb_boot_loader dut_u (
        .clk(clk), .reset_n(reset_n), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .boot_cfg_bytes(cfg), .host_assisted(host), .mem_aperture_base(mbase),
        .reg_aperture_base(rbase), .prog_wr_valid(pvalid), .prog_wr_ready(rdy),
        .prog_wr_addr(paddr), .prog_wr_data(pdata), .highway_release(hwy),
        .core_release(core), .boot_busy(busy), .boot_error(err)
    );
    seb_eeprom_model p_u (.scl(scl_w), .sda(sda_w), .sda_oe(m_oe), .present(present));
    function [7:0] bt(input integer k);
        if (k == 0)
            bt = 8'h70; // Fastest divider choice
        else if (k == 9)
            bt = {mode_r, 7'h15};
        else if (k == 14)
            bt = 8'h00;
        else if (k == 15)
            bt = len_r;
        else
            bt = k[7:0] * 8'h1d + 8'h35;
    endfunction
    task chk(input [79:0] seen, input [79:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task start_boot(input m, input r);
        mode_r = m;
        rdy = r;
        for (i = 0; i < 2048; i = i + 1)
            p_u.mem[i] = bt(i);
        reset_n = 1'b0;
        repeat (8) @(negedge clk);
        n_rise = 0;
        taken = 0;
        reset_n = 1'b1;
    endtask
    task wait_done;
        for (i = 0; i < 70000 && busy !== 1'b0; i = i + 1)
            @(negedge clk);
        repeat (4) @(negedge clk);
        chk(busy, 1'b0);
    endtask
    always @(negedge clk) cyc = cyc + 1;
    always @(posedge scl_w)
    begin
        n_rise = n_rise + 1;
        if (n_rise == 2)
            first_per = cyc - last_rise;
        if (p_u.phase_ff == 2'h2 && p_u.ptr_ff == 11'h005)
            mid_per = cyc - last_rise;
        last_rise = cyc;
    end
    always @(posedge clk)
        if (pvalid === 1'b1 && rdy)
        begin
            chk(paddr, taken);
            chk(pdata, bt(taken + 16));
            taken = taken + 1;
        end
    task t_nack;
        present = 1'b0;
        start_boot(1'b1, 1'b1);
        for (i = 0; i < 15000 && err !== 1'b1; i = i + 1)
            @(negedge clk);
        repeat (200) @(negedge clk);
        chk(err, 1'b1);
        chk({hwy, core}, 2'h0);
        present = 1'b1;
    endtask
    task t_host;
        start_boot(1'b0, 1'b1);
        wait_done;
        for (i = 0; i < 10; i = i + 1)
            exp_cfg[8*i +: 8] = bt(i);
        chk(cfg, exp_cfg);
        chk(host, 1'b1);
        chk({hwy, core}, 2'h2);
        chk(p_u.ptr_ff, 11'h00a);
        chk(taken, 0);
        chk(first_per, 1000);
        chk(mid_per, 84);
    endtask
    task t_auto;
        start_boot(1'b1, 1'b0);
        for (i = 0; i < 60000 && pvalid !== 1'b1; i = i + 1)
            @(negedge clk);
        repeat (2000) @(negedge clk);
        chk({busy, core, pvalid, scl_oe, taken[1:0]}, 6'h28);
        rdy = 1'b1;
        wait_done;
        chk(taken, 3);
        chk(mbase, {bt(10), bt(11)});
        chk(rbase, {bt(12), bt(13)});
        chk({host, hwy, core}, 3'h3);
        chk(p_u.ptr_ff, 11'h013);
    endtask
    initial forever #12.5 clk = ~clk;
    initial
    begin
        @(negedge clk);
        t_nack;
        t_host;
        t_auto;
        give_verdict;
    end
    initial
    begin
        #(125000 * 25);
        n_fail = n_fail + 1;
        give_verdict;
    end
endmodule // testbench
